// [pcc_pkg.sv]
// Constants and types for the MAC-side clock, power and wake control block.
package pcc_pkg;

	// Core clock and the probe interval used in active sleep.
	localparam int CLK_PERIOD_NS = 100;
	localparam int NLP_INTERVAL_US = 1400000;
	localparam int NLP_CYCLES = NLP_INTERVAL_US * 1000 / CLK_PERIOD_NS;

	// Register indices; the byte address is four times the index.
	localparam logic [11:0] IDX_BASIC_CONTROL = 12'h000;
	localparam logic [11:0] IDX_PHY_SPECIFIC_CONTROL = 12'h011;
	localparam logic [11:0] IDX_INTERRUPT_STATUS_TWO = 12'h013;
	localparam logic [11:0] IDX_SELF_TEST_CONTROL = 12'h016;
	localparam logic [11:0] IDX_LED_GPIO_PIN_CONFIG = 12'h304;
	localparam logic [11:0] IDX_DEEP_POWERDOWN_CONTROL = 12'h428;
	localparam logic [11:0] IDX_WAKE_RECEIVE_CONFIG = 12'h4a0;
	localparam logic [11:0] IDX_WAKE_RECEIVE_STATUS = 12'h4a1;
	localparam logic [11:0] IDX_NODE_ADDRESS_0 = 12'h4a2;
	localparam logic [11:0] IDX_NODE_ADDRESS_1 = 12'h4a3;
	localparam logic [11:0] IDX_NODE_ADDRESS_2 = 12'h4a4;

	// Field positions and codes.
	localparam int BC_DUPLEX_BIT = 8;
	localparam int BC_POWERDOWN_BIT = 11;
	localparam int PSC_SLEEP_LSB = 12;
	localparam logic [2:0] SLEEP_ENABLE_CODE = 3'h6;
	localparam int ISR2_WAKE_FLAG_BIT = 1;
	localparam int ISR2_WAKE_EN_BIT = 9;
	localparam int DPD_PIN_FUNC_BIT = 0;
	localparam int DPD_ENABLE_BIT = 2;
	localparam int LED_FUNC_LSB = 0;
	localparam logic [2:0] LED_FUNC_INPUT = 3'h1;
	localparam int CLK_SRC_LSB = 4;
	localparam logic [1:0] CLK_SRC_IF = 2'h0;
	localparam logic [1:0] CLK_SRC_XI = 2'h1;
	localparam logic [1:0] CLK_SRC_FREE = 2'h2;
	localparam logic [1:0] CLK_SRC_RECOVERED = 2'h3;
	localparam int WAKE_CFG_EN_BIT = 0;
	localparam int WAKE_STAT_HIT_BIT = 0;

	// Values after reset.
	localparam logic [15:0] BASIC_CONTROL_RST = 16'h0100;
	localparam logic [15:0] LED_GPIO_PIN_CONFIG_RST = 16'h0010;
	localparam logic [3:0] CLK_SRC_ONEHOT_RST = 4'h2;

	// Wake frame layout.
	localparam logic [7:0] SYNC_BYTE = 8'hff;
	localparam logic [2:0] SYNC_BYTES = 3'h6;
	localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
	localparam logic [4:0] ADDR_LAST_COPY = 5'h0f;

	// Cycles of settling before the straps are caught.
	localparam logic [2:0] STRAP_SETTLE = 3'h5;

	// Positions in the synchroniser vector.
	localparam int SYNC_W = 11;
	localparam int SY_IF_CLK = 0;
	localparam int SY_ENERGY = 1;
	localparam int SY_PWRDN_N = 2;
	localparam int SY_TX_EN = 3;
	localparam int SY_TX_D = 4;
	localparam int SY_RMII = 8;
	localparam int SY_LEADER = 9;
	localparam int SY_REPEATER = 10;

	typedef enum logic [1:0] {
		PWR_ACTIVE,
		PWR_SLEEP,
		PWR_DOWN,
		PWR_DEEP
	} pcc_power_type;

	typedef struct packed {
		logic dv;
		logic er;
		logic [3:0] data;
		logic crs;
		logic col;
		logic crs_dv;
	} pcc_mac_rx_type;

	typedef struct packed {
		logic en;
		logic [3:0] data;
	} pcc_line_tx_type;

endpackage

// [pcc_phy_mac_side.sv]
// MAC-side data path, clock output select, low-power states and wake detection.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RL1: Wake detection settings live in a config register at extended index 0x4a0.
// RL2: Wake detection outcome is reported in a status register at index 0x4a1.
// RL3: Wake frame is six 0xff bytes then sixteen unbroken node address copies.
// RL4: Bits 14 to 12 of phy specific control equal 110 enable active sleep.
// RL5: Sleep enabled and no cable energy: sleep, only management and detection stay powered. The code keeps PLL_EN high in sleep.
// RL6: In active sleep a link pulse goes out every 1.4 seconds.
// RL7: Partner energy in sleep returns to normal operation and restores full power.
// RL8: Bit 11 of basic control set enters standard power-down.
// RL9: The outside party drives the power-down pin low to request power-down.
// RL10: Software sets deep enable bit 2 first, then requests power-down.
// RL11: Deep power-down also stops the PLL; only management logic remains.
// RL12: Repeater strap turns the RMII carrier/valid output into pure receive valid.
// RL13: Interface clock output runs at the active interface rate, 50 MHz in RMII.
// RL14: After reset the clock pin carries the buffered crystal input clock.
// RL15: A free-running PLL clock is offered as a clock output source.
// RL16: The recovered clock source comes from received line data, not local reference.
// RL17: Pin function field set to input disables the clock output.
// RL18: MII moves one 4-bit nibble per interface clock in each direction.
// RL19: Carrier sense asserts while receiving or transmitting.
// RL20: In half duplex collision asserts while transmit and receive overlap.
// RL21: RMII leader runs from 25 MHz and supplies a 50 MHz reference out.
// RL22: In RMII follower the system supplies 50 MHz on the crystal input.
// RL23: RMII moves two bits per reference clock each way on separate paths.
// RL24: RMII transmit is sampled and receive presented on the reference clock.
// RL25: Clock source select is one of four, crystal pass-through after reset.
module pcc_phy_mac_side #(
	parameter int NLP_CYCLES = pcc_pkg::NLP_CYCLES,
	parameter int ADDR_W = 16
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// APB register bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// MAC interface
	input wire logic IF_CLK,
	input wire logic TX_EN,
	input wire logic [3:0] TX_D,
	output logic [3:0] RX_D,
	output logic RX_DV,
	output logic RX_ER,
	output logic CRS,
	output logic COL,
	output logic CRS_DV,
	// Line side
	input wire logic LINE_RX_VALID,
	input wire logic LINE_RX_ERROR,
	input wire logic LINE_RX_CARRIER,
	input wire logic [3:0] LINE_RX_DATA,
	input wire logic ENERGY_DETECT,
	output logic LINE_TX_EN,
	output logic [3:0] LINE_TX_DATA,
	output logic NLP_PULSE,
	// Straps and power
	input wire logic RMII_MODE_STRAP,
	input wire logic LEADER_STRAP,
	input wire logic REPEATER_STRAP,
	input wire logic INTERRUPT_OR_POWERDOWN_PIN_N,
	output logic ANALOG_POWER_EN,
	output logic PLL_EN,
	output logic WAKE_EVENT,
	// Clock output
	output logic [3:0] CLKOUT_SOURCE,
	output logic CLOCK_OUT_LED_PIN_OE_N,
	output logic REF_CLK_OUT_EN,
	output logic IF_CLK_RMII_RATE
);

	typedef struct packed {
		logic [15:0] basic_control;
		logic [15:0] phy_specific_control;
		logic [15:0] isr2;
		logic [15:0] led_cfg;
		logic [15:0] dpd_ctrl;
		logic [15:0] wake_cfg;
		logic [15:0] wake_status;
		logic [2:0][15:0] node_addr;
		logic [31:0] prdata;
		logic [pcc_pkg::SYNC_W-1:0] s1;
		logic [pcc_pkg::SYNC_W-1:0] s2;
		logic [pcc_pkg::SYNC_W-1:0] s3;
		logic [pcc_pkg::SYNC_W-1:0] filt;
		logic [2:0] settle;
		logic strap_done;
		logic rmii;
		logic leader;
		logic repeater;
		pcc_pkg::pcc_power_type power;
		logic [23:0] nlp_count;
		logic nlp_pulse;
		logic [2:0] sync_count;
		logic [2:0] addr_byte;
		logic [4:0] copies;
		logic [7:0] rx_byte;
		logic [2:0] bit_count;
		logic wake_event;
		pcc_pkg::pcc_mac_rx_type mac_rx;
		pcc_pkg::pcc_line_tx_type line_tx;
		logic [3:0] clk_src;
		logic clk_oe_n;
		logic pll_en;
		logic analog_en;
	} pcc_state_type;

	pcc_state_type st;
	pcc_state_type next_st;

	logic [pcc_pkg::SYNC_W-1:0] pin_vec;
	logic if_edge;
	logic pd_req;
	logic sleep_en;
	logic energy;
	logic tx_en_s;
	logic [3:0] tx_d_s;
	logic apb_setup;
	logic apb_access;
	logic [11:0] reg_index;
	logic [15:0] rd_value;
	logic rd_hit;
	logic [3:0] bit_sum;
	logic [7:0] rx_next_byte;
	logic [15:0] exp_word;
	logic [7:0] exp_byte;
	logic wake_hit;
	logic [1:0] src_field;

	assign pin_vec = {REPEATER_STRAP, LEADER_STRAP, RMII_MODE_STRAP, TX_D, TX_EN,
		INTERRUPT_OR_POWERDOWN_PIN_N, ENERGY_DETECT, IF_CLK};
	// An interface clock rising edge counts once the second and third stages agree high.
	assign if_edge = !st.filt[pcc_pkg::SY_IF_CLK] && st.s2[pcc_pkg::SY_IF_CLK] &&
		st.s3[pcc_pkg::SY_IF_CLK];
	assign energy = st.filt[pcc_pkg::SY_ENERGY];
	assign tx_en_s = st.filt[pcc_pkg::SY_TX_EN];
	assign tx_d_s = st.filt[pcc_pkg::SY_TX_D +: 4];
	assign sleep_en = st.phy_specific_control[pcc_pkg::PSC_SLEEP_LSB +: 3] ==
		pcc_pkg::SLEEP_ENABLE_CODE; // RL4
	// The pin is ignored until the synchronisers have settled after reset.
	assign pd_req = st.basic_control[pcc_pkg::BC_POWERDOWN_BIT] ||
		(st.strap_done && st.dpd_ctrl[pcc_pkg::DPD_PIN_FUNC_BIT] &&
		!st.filt[pcc_pkg::SY_PWRDN_N]); // RL8 RL9
	assign apb_setup = PSEL && !PENABLE;
	assign apb_access = PSEL && PENABLE;
	assign reg_index = PADDR[13:2];
	assign bit_sum = {1'b0, st.bit_count} + (st.rmii ? 4'h2 : 4'h4);
	assign rx_next_byte = st.rmii ? {LINE_RX_DATA[1:0], st.rx_byte[7:2]} :
		{LINE_RX_DATA, st.rx_byte[7:4]};
	assign exp_word = st.node_addr[st.addr_byte[2:1]];
	assign exp_byte = st.addr_byte[0] ? exp_word[7:0] : exp_word[15:8];
	assign src_field = st.led_cfg[pcc_pkg::CLK_SRC_LSB +: 2];

	always_comb begin
		next_st = st;
		rd_value = 16'h0000;
		rd_hit = 1'b1;
		wake_hit = 1'b0;

		next_st.s1 = pin_vec;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < pcc_pkg::SYNC_W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.filt[i] = st.s3[i];
			end
		end

		if (!st.strap_done) begin
			if (st.settle == pcc_pkg::STRAP_SETTLE) begin
				next_st.strap_done = 1'b1;
				next_st.rmii = st.filt[pcc_pkg::SY_RMII];
				next_st.leader = st.filt[pcc_pkg::SY_LEADER];
				next_st.repeater = st.filt[pcc_pkg::SY_REPEATER];
			end else begin
				next_st.settle = st.settle + 3'h1;
			end
		end

		// Register read decode.
		case (reg_index)
			pcc_pkg::IDX_BASIC_CONTROL: rd_value = st.basic_control;
			pcc_pkg::IDX_PHY_SPECIFIC_CONTROL: rd_value = st.phy_specific_control;
			pcc_pkg::IDX_INTERRUPT_STATUS_TWO: rd_value = st.isr2;
			pcc_pkg::IDX_SELF_TEST_CONTROL: rd_value = {13'h0000, sleep_en, st.power};
			pcc_pkg::IDX_LED_GPIO_PIN_CONFIG: rd_value = st.led_cfg;
			pcc_pkg::IDX_DEEP_POWERDOWN_CONTROL: rd_value = st.dpd_ctrl;
			pcc_pkg::IDX_WAKE_RECEIVE_CONFIG: rd_value = st.wake_cfg; // RL1
			pcc_pkg::IDX_WAKE_RECEIVE_STATUS: rd_value = st.wake_status; // RL2
			pcc_pkg::IDX_NODE_ADDRESS_0: rd_value = st.node_addr[0];
			pcc_pkg::IDX_NODE_ADDRESS_1: rd_value = st.node_addr[1];
			pcc_pkg::IDX_NODE_ADDRESS_2: rd_value = st.node_addr[2];
			default: rd_hit = 1'b0;
		endcase

		if (apb_setup) begin
			next_st.prdata = {16'h0000, rd_value};
		end

		if (apb_access && PWRITE) begin
			case (reg_index)
				pcc_pkg::IDX_BASIC_CONTROL: next_st.basic_control = PWDATA[15:0];
				pcc_pkg::IDX_PHY_SPECIFIC_CONTROL: next_st.phy_specific_control = PWDATA[15:0];
				pcc_pkg::IDX_INTERRUPT_STATUS_TWO: next_st.isr2[pcc_pkg::ISR2_WAKE_EN_BIT] =
					PWDATA[pcc_pkg::ISR2_WAKE_EN_BIT];
				pcc_pkg::IDX_LED_GPIO_PIN_CONFIG: next_st.led_cfg = PWDATA[15:0];
				pcc_pkg::IDX_DEEP_POWERDOWN_CONTROL: next_st.dpd_ctrl = PWDATA[15:0]; // RL10
				pcc_pkg::IDX_WAKE_RECEIVE_CONFIG: next_st.wake_cfg = PWDATA[15:0]; // RL1
				pcc_pkg::IDX_NODE_ADDRESS_0: next_st.node_addr[0] = PWDATA[15:0];
				pcc_pkg::IDX_NODE_ADDRESS_1: next_st.node_addr[1] = PWDATA[15:0];
				pcc_pkg::IDX_NODE_ADDRESS_2: next_st.node_addr[2] = PWDATA[15:0];
				default: ;
			endcase
		end

		// Status flags clear on read only if the read data showed them set.
		// A flag raised at the setup edge is not in PRDATA and must survive.
		// A set in the same cycle as the clear wins below.
		if (apb_access && !PWRITE) begin
			if (reg_index == pcc_pkg::IDX_WAKE_RECEIVE_STATUS &&
				st.prdata[pcc_pkg::WAKE_STAT_HIT_BIT]) begin
				next_st.wake_status[pcc_pkg::WAKE_STAT_HIT_BIT] = 1'b0;
			end
			if (reg_index == pcc_pkg::IDX_INTERRUPT_STATUS_TWO &&
				st.prdata[pcc_pkg::ISR2_WAKE_FLAG_BIT]) begin
				next_st.isr2[pcc_pkg::ISR2_WAKE_FLAG_BIT] = 1'b0;
			end
		end

		// Power state.
		case (st.power)
			pcc_pkg::PWR_ACTIVE: begin
				if (pd_req) begin
					next_st.power = st.dpd_ctrl[pcc_pkg::DPD_ENABLE_BIT] ?
						pcc_pkg::PWR_DEEP : pcc_pkg::PWR_DOWN; // RL8 RL10
				end else if (sleep_en && !energy) begin
					next_st.power = pcc_pkg::PWR_SLEEP; // RL5
				end
			end
			pcc_pkg::PWR_SLEEP: begin
				if (pd_req) begin
					next_st.power = st.dpd_ctrl[pcc_pkg::DPD_ENABLE_BIT] ?
						pcc_pkg::PWR_DEEP : pcc_pkg::PWR_DOWN;
				end else if (energy || !sleep_en) begin
					next_st.power = pcc_pkg::PWR_ACTIVE; // RL7
				end
			end
			pcc_pkg::PWR_DOWN, pcc_pkg::PWR_DEEP: begin
				if (!pd_req) begin
					next_st.power = pcc_pkg::PWR_ACTIVE;
				end
			end
			default: next_st.power = pcc_pkg::PWR_ACTIVE;
		endcase
		next_st.analog_en = next_st.power == pcc_pkg::PWR_ACTIVE; // RL5 RL7 RL8
		next_st.pll_en = next_st.power != pcc_pkg::PWR_DEEP; // RL11

		// Link pulse timer, running only while asleep.
		next_st.nlp_pulse = 1'b0;
		if (st.power == pcc_pkg::PWR_SLEEP) begin
			if (st.nlp_count == 24'(NLP_CYCLES - 1)) begin
				next_st.nlp_count = 24'h000000;
				next_st.nlp_pulse = 1'b1; // RL6
			end else begin
				next_st.nlp_count = st.nlp_count + 24'h000001;
			end
		end else begin
			next_st.nlp_count = 24'h000000;
		end

		// Data path, one transfer per interface clock rising edge.
		if (st.power != pcc_pkg::PWR_ACTIVE) begin
			next_st.mac_rx = '0;
			next_st.line_tx = '0;
		end else if (if_edge) begin
			next_st.line_tx.en = tx_en_s; // RL24
			next_st.line_tx.data = st.rmii ? {2'b00, tx_d_s[1:0]} : tx_d_s; // RL18 RL23
			next_st.mac_rx.dv = LINE_RX_VALID;
			next_st.mac_rx.er = LINE_RX_ERROR;
			next_st.mac_rx.data = st.rmii ? {2'b00, LINE_RX_DATA[1:0]} :
				LINE_RX_DATA; // RL18 RL23 RL24
			next_st.mac_rx.crs = LINE_RX_CARRIER || LINE_RX_VALID || tx_en_s; // RL19
			next_st.mac_rx.col = !st.basic_control[pcc_pkg::BC_DUPLEX_BIT] &&
				(LINE_RX_CARRIER || LINE_RX_VALID) && tx_en_s; // RL20
			next_st.mac_rx.crs_dv = st.repeater ? LINE_RX_VALID :
				(LINE_RX_CARRIER || LINE_RX_VALID); // RL12
		end

		// Wake frame scanner on the received stream.
		next_st.wake_event = 1'b0;
		if (st.power == pcc_pkg::PWR_ACTIVE && if_edge) begin
			if (!LINE_RX_VALID) begin
				next_st.sync_count = 3'h0;
				next_st.bit_count = 3'h0;
				next_st.addr_byte = 3'h0;
				next_st.copies = 5'h00;
			end else begin
				next_st.rx_byte = rx_next_byte;
				next_st.bit_count = bit_sum[2:0];
				if (bit_sum[3]) begin
					if (st.sync_count != pcc_pkg::SYNC_BYTES) begin
						next_st.sync_count = (rx_next_byte == pcc_pkg::SYNC_BYTE) ?
							st.sync_count + 3'h1 : 3'h0; // RL3
					end else if (rx_next_byte == exp_byte) begin
						if (st.addr_byte == pcc_pkg::ADDR_LAST_BYTE) begin
							next_st.addr_byte = 3'h0;
							next_st.copies = st.copies + 5'h01;
							if (st.copies == pcc_pkg::ADDR_LAST_COPY) begin
								wake_hit = 1'b1; // RL3
								next_st.sync_count = 3'h0;
								next_st.copies = 5'h00;
							end
						end else begin
							next_st.addr_byte = st.addr_byte + 3'h1;
						end
					end else if (!(st.addr_byte == 3'h0 && st.copies == 5'h00 &&
						rx_next_byte == pcc_pkg::SYNC_BYTE)) begin
						next_st.sync_count = (rx_next_byte == pcc_pkg::SYNC_BYTE) ?
							3'h1 : 3'h0; // RL3
						next_st.addr_byte = 3'h0;
						next_st.copies = 5'h00;
					end
				end
			end
		end
		if (wake_hit && st.wake_cfg[pcc_pkg::WAKE_CFG_EN_BIT]) begin
			next_st.wake_status[pcc_pkg::WAKE_STAT_HIT_BIT] = 1'b1; // RL2
			next_st.wake_event = 1'b1;
			if (st.isr2[pcc_pkg::ISR2_WAKE_EN_BIT]) begin
				next_st.isr2[pcc_pkg::ISR2_WAKE_FLAG_BIT] = 1'b1;
			end
		end

		// Clock output source and pin enable.
		next_st.clk_src = 4'h1 << src_field; // RL25 RL13 RL15 RL16
		next_st.clk_oe_n = (st.led_cfg[pcc_pkg::LED_FUNC_LSB +: 3] ==
			pcc_pkg::LED_FUNC_INPUT) ||
			(src_field == pcc_pkg::CLK_SRC_FREE && !st.pll_en); // RL17 RL15
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st <= '0;
			st.basic_control <= pcc_pkg::BASIC_CONTROL_RST;
			st.led_cfg <= pcc_pkg::LED_GPIO_PIN_CONFIG_RST; // RL14
			st.clk_src <= pcc_pkg::CLK_SRC_ONEHOT_RST; // RL14 RL25
			st.pll_en <= 1'b1;
			st.analog_en <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign PRDATA = st.prdata;
	assign PREADY = 1'b1;
	assign PSLVERR = apb_access && !rd_hit;
	assign RX_D = st.mac_rx.data;
	assign RX_DV = st.mac_rx.dv;
	assign RX_ER = st.mac_rx.er;
	assign CRS = st.mac_rx.crs;
	assign COL = st.mac_rx.col;
	assign CRS_DV = st.mac_rx.crs_dv;
	assign LINE_TX_EN = st.line_tx.en;
	assign LINE_TX_DATA = st.line_tx.data;
	assign NLP_PULSE = st.nlp_pulse;
	assign ANALOG_POWER_EN = st.analog_en;
	assign PLL_EN = st.pll_en;
	assign WAKE_EVENT = st.wake_event;
	assign CLKOUT_SOURCE = st.clk_src;
	assign CLOCK_OUT_LED_PIN_OE_N = st.clk_oe_n;
	// The leader supplies the 50 MHz reference only with its PLL running.
	assign REF_CLK_OUT_EN = st.rmii && st.leader && st.pll_en; // RL21
	assign IF_CLK_RMII_RATE = st.rmii; // RL13

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	sleep_entry_a: assert property ((st.power == pcc_pkg::PWR_ACTIVE) && !pd_req && // RL5
		sleep_en && !energy |=> (st.power == pcc_pkg::PWR_SLEEP) && !ANALOG_POWER_EN)
		else $error("active sleep not entered without energy");
	nlp_sleep_a: assert property (NLP_PULSE |-> // RL6
		($past(st.power) == pcc_pkg::PWR_SLEEP))
		else $error("link pulse outside active sleep");
	nlp_gap_a: assert property ($rose(NLP_PULSE) |=> !NLP_PULSE [*8]) // RL6
		else $error("link pulses too close");
	sleep_exit_a: assert property ((st.power == pcc_pkg::PWR_SLEEP) && energy && // RL7
		!pd_req |=> ANALOG_POWER_EN && (st.power == pcc_pkg::PWR_ACTIVE))
		else $error("no return from sleep on energy");
	reg_powerdown_a: assert property (st.basic_control[pcc_pkg::BC_POWERDOWN_BIT] // RL8
		|=> !ANALOG_POWER_EN)
		else $error("power-down bit did not remove power");
	deep_pll_a: assert property ((st.power == pcc_pkg::PWR_ACTIVE) && // RL11
		st.basic_control[pcc_pkg::BC_POWERDOWN_BIT] &&
		st.dpd_ctrl[pcc_pkg::DPD_ENABLE_BIT] |=> !PLL_EN && !ANALOG_POWER_EN)
		else $error("deep power-down left the PLL running");
	carrier_tx_a: assert property (if_edge && (st.power == pcc_pkg::PWR_ACTIVE) && // RL19
		tx_en_s |=> CRS && LINE_TX_EN)
		else $error("carrier sense missing while transmitting");
	collision_a: assert property (if_edge && (st.power == pcc_pkg::PWR_ACTIVE) && // RL20
		tx_en_s && LINE_RX_VALID && !st.basic_control[pcc_pkg::BC_DUPLEX_BIT] |=> COL)
		else $error("collision missing in half duplex");
	clk_input_a: assert property ((st.led_cfg[2:0] == pcc_pkg::LED_FUNC_INPUT) // RL17
		|=> CLOCK_OUT_LED_PIN_OE_N)
		else $error("clock pin driven while set as input");
	clk_onehot_a: assert property ($onehot(CLKOUT_SOURCE)) // RL25
		else $error("clock source not exactly one");
	repeater_dv_a: assert property (st.strap_done && st.repeater |-> // RL12
		(CRS_DV == RX_DV))
		else $error("repeater output is not receive valid");
	wake_flag_a: assert property (wake_hit && st.wake_cfg[pcc_pkg::WAKE_CFG_EN_BIT] // RL3
		|=> st.wake_status[pcc_pkg::WAKE_STAT_HIT_BIT] && WAKE_EVENT)
		else $error("wake frame not reported");

endmodule

`default_nettype wire

// [pcc_mac_model.sv]
// Behavioural MAC: interface clock, transmit nibbles and receive capture.
`timescale 1ns/1ps
`default_nettype none
module pcc_mac_model (
	// Core clock that times pin changes
	input wire logic CORE_CLK,
	// Bench control
	input wire logic tx_req,
	input wire logic [3:0] tx_nib,
	output logic [3:0] rx_last,
	// MAC pins
	output logic IF_CLK,
	output logic TX_EN,
	output logic [3:0] TX_D,
	input wire logic [3:0] RX_D,
	input wire logic RX_DV
);
	initial begin
		IF_CLK = 1'b0;
		TX_EN = 1'b0;
		TX_D = 4'h0;
		rx_last = 4'h0;
		#130;
		forever #400 IF_CLK = ~IF_CLK;
	end
	// Pins move half a period away from the rise that samples them.
	always @(negedge IF_CLK) begin
		@(posedge CORE_CLK);
		TX_EN <= tx_req;
		// Idle data toggles so nothing stale can pass for a nibble.
		TX_D <= tx_req ? tx_nib : ~TX_D;
		if (RX_DV === 1'b1) rx_last <= RX_D;
	end
endmodule
`default_nettype wire

// [pcc_phy_mac_side_tb_top.sv]
// Testbench for the MAC-side clock, power and wake control block.
`timescale 1ns/1ps
`default_nettype none
module pcc_phy_mac_side_tb_top;
	localparam int NLP = 20;
	logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] tx_d, rx_d, line_rx_data, line_tx_data, clkout_source;
	logic [3:0] tx_nib, rx_last;
	logic if_clk, tx_en, rx_dv, rx_er, crs, col, crs_dv, rx_valid, carrier;
	logic energy, line_tx_en, nlp_pulse, rmii, leader, repeater, pd_pin_n;
	logic apower, pll_en, wake, oe_n, ref_en, tx_req, rx_err, rmii_rate;
	int n_fail, n_compared, cycles, n_wake, n;
	pcc_phy_mac_side #(.NLP_CYCLES(NLP)) u_pcc_phy_mac_side (
		.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .IF_CLK(if_clk), .TX_EN(tx_en),
		.TX_D(tx_d), .RX_D(rx_d), .RX_DV(rx_dv), .RX_ER(rx_er), .CRS(crs),
		.COL(col), .CRS_DV(crs_dv), .LINE_RX_VALID(rx_valid),
		.LINE_RX_ERROR(rx_err), .LINE_RX_CARRIER(carrier),
		.LINE_RX_DATA(line_rx_data), .ENERGY_DETECT(energy),
		.LINE_TX_EN(line_tx_en), .LINE_TX_DATA(line_tx_data),
		.NLP_PULSE(nlp_pulse), .RMII_MODE_STRAP(rmii), .LEADER_STRAP(leader),
		.REPEATER_STRAP(repeater), .INTERRUPT_OR_POWERDOWN_PIN_N(pd_pin_n),
		.ANALOG_POWER_EN(apower), .PLL_EN(pll_en), .WAKE_EVENT(wake),
		.CLKOUT_SOURCE(clkout_source), .CLOCK_OUT_LED_PIN_OE_N(oe_n),
		.REF_CLK_OUT_EN(ref_en), .IF_CLK_RMII_RATE(rmii_rate));
	pcc_mac_model u_pcc_mac_model (.CORE_CLK(core_clk), .tx_req(tx_req),
		.tx_nib(tx_nib), .rx_last(rx_last), .IF_CLK(if_clk), .TX_EN(tx_en),
		.TX_D(tx_d), .RX_D(rx_d), .RX_DV(rx_dv));
	always #50 core_clk = ~core_clk;
	task automatic print_verdict;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (wake === 1'b1) n_wake <= n_wake + 1;
		if (cycles == 30000) begin
			n_fail++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	// One APB transfer; only the bench timeout ends the wait for pready.
	task automatic apb(input logic wr, input logic [11:0] idx,
		input logic [15:0] wd);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= {16'h0, wd};
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [11:0] idx,
		input logic [31:0] exp);
		apb(1'b0, idx, 16'h0);
		chk(what, exp, rd);
	endtask
	// Lands just after an interface clock rise, settled long before sampling.
	task automatic ifw(input int k);
		repeat (k) @(posedge if_clk);
		@(posedge core_clk);
	endtask
	task automatic line_byte(input logic [7:0] b);
		ifw(1);
		rx_valid <= 1'b1;
		line_rx_data <= b[3:0];
		ifw(1);
		line_rx_data <= b[7:4];
	endtask
	task automatic frame(input int copies);
		repeat (6) line_byte(8'hff);
		repeat (copies) for (int i = 0; i < 6; i++) line_byte(8'(8'h11 * (i + 1)));
		ifw(1);
		rx_valid <= 1'b0;
		line_rx_data <= ~line_rx_data;
		cyc(20);
	endtask
	initial begin
		{core_clk, rst_n, psel, penable, pwrite, rx_valid, carrier} = '0;
		{rmii, leader, repeater, tx_req, tx_nib, line_rx_data} = '0;
		{paddr, pwdata, rx_err} = '0;
		{energy, pd_pin_n} = 2'h3;
		{n_fail, n_compared, cycles, n_wake} = '0;
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		cyc(8);
		chk("clkout after reset", 32'h2, clkout_source);
		chk("mii rate", 32'h0, rmii_rate);
		rdchk("basic_control", pcc_pkg::IDX_BASIC_CONTROL, 32'h0100);
		rdchk("led config", pcc_pkg::IDX_LED_GPIO_PIN_CONFIG, 32'h0010);
		rdchk("wake config", pcc_pkg::IDX_WAKE_RECEIVE_CONFIG, 32'h0);
		apb(1'b1, pcc_pkg::IDX_WAKE_RECEIVE_STATUS, 16'hffff);
		rdchk("wake status", pcc_pkg::IDX_WAKE_RECEIVE_STATUS, 32'h0);
		apb(1'b0, 12'h005, 16'h0);
		chk("unmapped error", 32'h1, err);
		chk("unmapped data", 32'h0, rd);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, pcc_pkg::IDX_LED_GPIO_PIN_CONFIG, 16'(s << 4));
			cyc(2);
			chk("clock source", 32'(4'h1 << s), clkout_source);
			chk("clock pin on", 32'h0, oe_n);
		end
		apb(1'b1, pcc_pkg::IDX_LED_GPIO_PIN_CONFIG, 16'h0011);
		cyc(2);
		chk("clock pin off", 32'h1, oe_n);
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0900);
		cyc(3);
		chk("analog power", 32'h0, apower);
		chk("pll in power-down", 32'h1, pll_en);
		rdchk("state down", pcc_pkg::IDX_SELF_TEST_CONTROL, 32'h2);
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0100);
		apb(1'b1, pcc_pkg::IDX_DEEP_POWERDOWN_CONTROL, 16'h0004);
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0900);
		cyc(3);
		chk("pll in deep", 32'h0, pll_en);
		rdchk("state deep", pcc_pkg::IDX_SELF_TEST_CONTROL, 32'h3);
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0100);
		apb(1'b1, pcc_pkg::IDX_DEEP_POWERDOWN_CONTROL, 16'h0001);
		pd_pin_n <= 1'b0;
		cyc(8);
		rdchk("state pin down", pcc_pkg::IDX_SELF_TEST_CONTROL, 32'h2);
		pd_pin_n <= 1'b1;
		apb(1'b1, pcc_pkg::IDX_PHY_SPECIFIC_CONTROL, 16'h7000);
		energy <= 1'b0;
		cyc(8);
		chk("no sleep on 111", 32'h1, apower);
		apb(1'b1, pcc_pkg::IDX_PHY_SPECIFIC_CONTROL, 16'h6000);
		cyc(4);
		chk("sleep power", 32'h0, apower);
		rdchk("state sleep", pcc_pkg::IDX_SELF_TEST_CONTROL, 32'h5);
		n = 0;
		while (nlp_pulse !== 1'b1 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (nlp_pulse !== 1'b1 && n < 100);
		chk("pulse gap", NLP, n);
		energy <= 1'b1;
		cyc(8);
		chk("wake power", 32'h1, apower);
		tx_req <= 1'b1;
		tx_nib <= 4'ha;
		ifw(2);
		cyc(6);
		chk("line tx data", 32'ha, line_tx_data);
		chk("line tx en", 32'h1, line_tx_en);
		chk("carrier on tx", 32'h1, crs);
		chk("no col full", 32'h0, col);
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0000);
		rx_valid <= 1'b1;
		rx_err <= 1'b1;
		line_rx_data <= 4'h5;
		ifw(2);
		cyc(6);
		chk("col half", 32'h1, col);
		chk("rx data", 32'h5, rx_d);
		chk("rx error", 32'h1, rx_er);
		chk("rx valid", 32'h1, rx_dv);
		chk("mac got", 32'h5, rx_last);
		tx_req <= 1'b0;
		rx_valid <= 1'b0;
		rx_err <= 1'b0;
		apb(1'b1, pcc_pkg::IDX_BASIC_CONTROL, 16'h0100);
		apb(1'b1, pcc_pkg::IDX_NODE_ADDRESS_0, 16'h1122);
		apb(1'b1, pcc_pkg::IDX_NODE_ADDRESS_1, 16'h3344);
		apb(1'b1, pcc_pkg::IDX_NODE_ADDRESS_2, 16'h5566);
		apb(1'b1, pcc_pkg::IDX_INTERRUPT_STATUS_TWO, 16'h0200);
		apb(1'b1, pcc_pkg::IDX_WAKE_RECEIVE_CONFIG, 16'h0001);
		frame(15);
		chk("short frame", 32'h0, n_wake);
		frame(16);
		chk("wake pulse", 32'h1, n_wake);
		rdchk("wake seen", pcc_pkg::IDX_WAKE_RECEIVE_STATUS, 32'h1);
		rdchk("wake cleared", pcc_pkg::IDX_WAKE_RECEIVE_STATUS, 32'h0);
		rdchk("wake flag", pcc_pkg::IDX_INTERRUPT_STATUS_TWO, 32'h0202);
		{rmii, leader, repeater} <= 3'h7;
		rst_n <= 1'b0;
		cyc(3);
		rst_n <= 1'b1;
		cyc(10);
		chk("ref clock out", 32'h1, ref_en);
		chk("rmii rate", 32'h1, rmii_rate);
		carrier <= 1'b1;
		tx_req <= 1'b1;
		ifw(2);
		cyc(6);
		chk("repeater valid", 32'h0, crs_dv);
		chk("rmii tx dibit", 32'h2, line_tx_data);
		rx_valid <= 1'b1;
		line_rx_data <= 4'hf;
		ifw(2);
		cyc(6);
		chk("repeater valid", 32'h1, crs_dv);
		chk("rmii dibit", 32'h3, rx_d);
		print_verdict();
	end
endmodule
`default_nettype wire
